// ---- bench/ieb_top_chk.sv ----
`timescale 1ns/1ns
`default_nettype none

module ieb_top_chk
    import ieb_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock, reset and bus
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic irq,
    // Flags
    input wire logic [15:3] flag_two_upper,
    input wire logic can_one_receive,
    input wire logic spi_two_event,
    input wire logic spi_two_error,
    input wire logic dma_five_done,
    input wire logic pwm_error,
    input wire logic i2c_two_slave,
    input wire logic timer_seven,
    // Gated requests
    input wire logic [15:3] req_two_upper,
    input wire logic can_one_receive_req,
    input wire logic spi_two_event_req,
    input wire logic spi_two_error_req,
    input wire logic dma_five_done_req,
    input wire logic pwm_error_req,
    input wire logic i2c_two_slave_req,
    input wire logic timer_seven_req
);
    typedef struct packed {
        logic [15:0] e2;
        logic [15:0] e3;
    } ieb_shadow_t;
    ieb_shadow_t sh_q;
    ieb_shadow_t sh_d;
    logic wr_acc;
    logic rd_three;

    // ------------------------------------------------------------------
    // Shadow of the enables, kept from bus writes
    // ------------------------------------------------------------------
    assign wr_acc = psel && penable && pwrite;
    assign rd_three = psel && penable && !pwrite && paddr == ADDR_W'(IEB_OFF_ENABLE_THREE);
    always_comb begin
        sh_d = sh_q;
        if (wr_acc && paddr == ADDR_W'(IEB_OFF_ENABLE_TWO)) begin
            sh_d.e2 = pwdata[15:0] & IEB_IMPL_TWO;
        end
        if (wr_acc && paddr == ADDR_W'(IEB_OFF_ENABLE_THREE)) begin
            sh_d.e3 = pwdata[15:0] & IEB_IMPL_THREE;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_q <= '0;
        end else begin
            sh_q <= sh_d;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_GATE_UPPER: assert property (req_two_upper == $past(flag_two_upper & sh_q.e2[15:3]))
        else $error("upper request differs from flag and enable");
    AST_GATE_CAN_ONE: assert property (can_one_receive_req == $past(can_one_receive & sh_q.e2[2]))
        else $error("can one receive request wrong");
    AST_GATE_SPI_EVT: assert property (spi_two_event_req == $past(spi_two_event & sh_q.e2[1]))
        else $error("spi two event request wrong");
    AST_GATE_SPI_ERR: assert property (spi_two_error_req == $past(spi_two_error & sh_q.e2[0]))
        else $error("spi two error request wrong");
    AST_GATE_DMA_FIVE: assert property (dma_five_done_req == $past(dma_five_done & sh_q.e3[13]))
        else $error("dma five request wrong");
    AST_GATE_PWM_ERR: assert property (pwm_error_req == $past(pwm_error & sh_q.e3[9]))
        else $error("pwm error request wrong");
    AST_GATE_I2C_SLAVE: assert property (i2c_two_slave_req == $past(i2c_two_slave & sh_q.e3[1]))
        else $error("i2c slave request wrong");
    AST_GATE_TIMER_SEVEN: assert property (timer_seven_req == $past(timer_seven & sh_q.e3[0]))
        else $error("timer seven request wrong");
    AST_READ_THREE: assert property (rd_three |-> prdata == {16'h0000, sh_q.e3})
        else $error("third enable read data wrong");
    AST_RESET_QUIET: assert property ($rose(rst_n) |-> !irq && !timer_seven_req && !dma_five_done_req)
        else $error("request or interrupt active after reset");

    cover property ($rose(irq));
    cover property (dma_five_done_req);
    cover property (rd_three);
endmodule

bind ieb_top ieb_top_chk #(.ADDR_W(ADDR_W)) ieb_top_chk_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .irq(irq),
    .flag_two_upper(flag_two_upper), .can_one_receive(can_one_receive),
    .spi_two_event(spi_two_event), .spi_two_error(spi_two_error),
    .dma_five_done(dma_five_done), .pwm_error(pwm_error), .i2c_two_slave(i2c_two_slave),
    .timer_seven(timer_seven), .req_two_upper(req_two_upper),
    .can_one_receive_req(can_one_receive_req), .spi_two_event_req(spi_two_event_req),
    .spi_two_error_req(spi_two_error_req), .dma_five_done_req(dma_five_done_req),
    .pwm_error_req(pwm_error_req), .i2c_two_slave_req(i2c_two_slave_req),
    .timer_seven_req(timer_seven_req));

`default_nettype wire

// ---- bench/tb_interrupt_enable_bank.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb_interrupt_enable_bank;
    import ieb_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [15:0] f2 = 16'h0000;
    logic [15:0] f3 = 16'h0000;
    wire [15:0] q2;
    wire [15:0] q3;
    assign q3[14] = 1'b0;
    assign q3[12:11] = 2'b00;
    logic [31:0] rdat;
    logic rerr;
    int checks = 0;
    int miscompares = 0;
    int e2m;
    int e3m;
    logic [7:0] offs [5] = '{IEB_OFF_ENABLE_TWO, IEB_OFF_ENABLE_THREE, IEB_OFF_STATUS,
        IEB_OFF_MASK, IEB_OFF_REQUEST};

    always #10 ref_clk = ~ref_clk;

    ieb_top #(.ADDR_W(8)) ieb_top_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flag_two_upper(f2[15:3]), .can_one_receive(f2[2]), .spi_two_event(f2[1]),
        .spi_two_error(f2[0]), .pwm_fault_a(f3[15]), .dma_five_done(f3[13]),
        .quad_encoder(f3[10]), .pwm_error(f3[9]), .can_two_event(f3[8]),
        .can_two_receive(f3[7]), .ext_irq_four(f3[6]), .ext_irq_three(f3[5]),
        .timer_nine(f3[4]), .timer_eight(f3[3]), .i2c_two_master(f3[2]),
        .i2c_two_slave(f3[1]), .timer_seven(f3[0]), .req_two_upper(q2[15:3]),
        .can_one_receive_req(q2[2]), .spi_two_event_req(q2[1]), .spi_two_error_req(q2[0]),
        .pwm_fault_a_req(q3[15]), .dma_five_done_req(q3[13]), .quad_encoder_req(q3[10]),
        .pwm_error_req(q3[9]), .can_two_event_req(q3[8]), .can_two_receive_req(q3[7]),
        .ext_irq_four_req(q3[6]), .ext_irq_three_req(q3[5]), .timer_nine_req(q3[4]),
        .timer_eight_req(q3[3]), .i2c_two_master_req(q3[2]), .i2c_two_slave_req(q3[1]),
        .timer_seven_req(q3[0]), .irq(irq));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks++;
        if (got !== ex) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // Waits on pready, never on a fixed count; the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic stop_test();
        $display("Checks %0d, miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #200_000;
        miscompares++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'haa38_e0bb));
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (offs[k]) begin
            apb(1'b0, offs[k], '0);
            chk("reset value", 32'h0000_0000, rdat);
        end
        apb(1'b1, IEB_OFF_ENABLE_THREE, 32'hFFFF_FFFF);
        apb(1'b0, IEB_OFF_ENABLE_THREE, '0);
        chk("enable three all ones", 32'h0000_A7FF, rdat);
        for (int i = 0; i < 24; i++) begin
            e2m = $urandom;
            e3m = $urandom;
            apb(1'b1, IEB_OFF_ENABLE_TWO, 32'(e2m));
            apb(1'b1, IEB_OFF_ENABLE_THREE, 32'(e3m));
            e2m = e2m & IEB_IMPL_TWO;
            e3m = e3m & IEB_IMPL_THREE;
            f2 <= 16'($urandom);
            f3 <= 16'($urandom);
            repeat (3) @(posedge ref_clk);
            chk("req two", 32'(f2 & e2m[15:0]), 32'(q2));
            chk("req three", 32'(f3 & e3m[15:0]), 32'(q3 & IEB_IMPL_THREE));
            apb(1'b0, IEB_OFF_REQUEST, '0);
            chk("request reg", {f3 & e3m[15:0], f2 & e2m[15:0]}, rdat);
            apb(1'b0, IEB_OFF_ENABLE_THREE, '0);
            chk("enable three", 32'(e3m), rdat);
        end
        // Unmapped place: refused, nothing changes
        apb(1'b1, 8'h20, 32'hFFFF_FFFF);
        chk("write error", 32'h0000_0001, 32'(rerr));
        apb(1'b0, 8'h20, '0);
        chk("read error", 32'h0000_0001, 32'(rerr));
        chk("unmapped data", 32'h0000_0000, rdat);
        apb(1'b0, IEB_OFF_ENABLE_TWO, '0);
        chk("enable two", 32'(e2m), rdat);
        // Interrupt: masked, read-clear, then unmasked
        f2 <= 16'h0000;
        f3 <= 16'h0000;
        apb(1'b1, IEB_OFF_ENABLE_THREE, 32'h0000_0001);
        apb(1'b1, IEB_OFF_MASK, 32'h0000_0000);
        apb(1'b0, IEB_OFF_STATUS, '0);
        f3 <= 16'h0001;
        repeat (4) @(posedge ref_clk);
        chk("masked irq", 32'h0000_0000, 32'(irq));
        apb(1'b0, IEB_OFF_STATUS, '0);
        chk("status", 32'h0001_0000, rdat);
        apb(1'b0, IEB_OFF_STATUS, '0);
        chk("status cleared", 32'h0000_0000, rdat);
        apb(1'b1, IEB_OFF_MASK, 32'h0001_0000);
        f3 <= 16'h0000;
        repeat (2) @(posedge ref_clk);
        f3 <= 16'h0001;
        repeat (4) @(posedge ref_clk);
        chk("irq", 32'h0000_0001, 32'(irq));
        apb(1'b0, IEB_OFF_STATUS, '0);
        repeat (2) @(posedge ref_clk);
        chk("irq cleared", 32'h0000_0000, 32'(irq));
        stop_test();
    end
endmodule

`default_nettype wire

// ---- core/ieb_gate.sv ----
`timescale 1ns/1ns
`default_nettype none

module ieb_gate #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Source flags and their enables
    input wire logic [WIDTH-1:0] flag,
    input wire logic [WIDTH-1:0] enable,
    // Gated requests and their rising-edge events
    output logic [WIDTH-1:0] req,
    output logic [WIDTH-1:0] evt
);

    typedef struct packed {
        logic [WIDTH-1:0] req;
        logic [WIDTH-1:0] evt;
    } ieb_gate_state_t;

    ieb_gate_state_t state_q;
    ieb_gate_state_t state_d;
    logic [WIDTH-1:0] req_next;

    if (WIDTH < 1) begin : g_bad_width
        $error("ieb_gate: WIDTH must be at least 1");
    end

    // ------------------------------------------------------------------
    // Per-source gate
    // ------------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_src
        assign req_next[i] = flag[i] & enable[i];
    end

    // Only a fresh request counts, so a held flag is one event
    always_comb begin
        state_d.req = req_next;
        state_d.evt = req_next & ~state_q.req;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign req = state_q.req;
    assign evt = state_q.evt;

endmodule

`default_nettype wire

// ---- core/ieb_pkg.sv ----
package ieb_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] IEB_OFF_ENABLE_TWO = 8'h00;
    localparam logic [7:0] IEB_OFF_ENABLE_THREE = 8'h04;
    localparam logic [7:0] IEB_OFF_STATUS = 8'h08;
    localparam logic [7:0] IEB_OFF_MASK = 8'h0C;
    localparam logic [7:0] IEB_OFF_REQUEST = 8'h10;

    // ------------------------------------------------------------------
    // Widths, reset values and implemented-bit masks
    // ------------------------------------------------------------------
    localparam int IEB_REG_W = 16;
    localparam int IEB_SRC_W = 32;
    localparam logic [15:0] IEB_RST_ENABLE = 16'h0000;
    localparam logic [31:0] IEB_RST_STATUS = 32'h0000_0000;
    localparam logic [31:0] IEB_RST_MASK = 32'h0000_0000;
    localparam logic [31:0] IEB_RST_RDATA = 32'h0000_0000;
    localparam logic [15:0] IEB_IMPL_TWO = 16'hDFFF;
    localparam logic [15:0] IEB_IMPL_THREE = 16'hA7FF;

    // ------------------------------------------------------------------
    // Bit positions, second enable register
    // ------------------------------------------------------------------
    localparam int IEB_B2_CAN_ONE_RX = 2;
    localparam int IEB_B2_SPI_TWO_EVT = 1;
    localparam int IEB_B2_SPI_TWO_ERR = 0;
    localparam int IEB_B2_UPPER_LO = 3;

    // ------------------------------------------------------------------
    // Bit positions, third enable register
    // ------------------------------------------------------------------
    localparam int IEB_B3_PWM_FAULT_A = 15;
    localparam int IEB_B3_DMA_FIVE = 13;
    localparam int IEB_B3_QUAD_ENC = 10;
    localparam int IEB_B3_PWM_ERR = 9;
    localparam int IEB_B3_CAN_TWO_EVT = 8;
    localparam int IEB_B3_CAN_TWO_RX = 7;
    localparam int IEB_B3_EXT_FOUR = 6;
    localparam int IEB_B3_EXT_THREE = 5;
    localparam int IEB_B3_TIMER_NINE = 4;
    localparam int IEB_B3_TIMER_EIGHT = 3;
    localparam int IEB_B3_I2C_MASTER = 2;
    localparam int IEB_B3_I2C_SLAVE = 1;
    localparam int IEB_B3_TIMER_SEVEN = 0;

    // ------------------------------------------------------------------
    // Register state of the top level
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] enable_two;
        logic [15:0] enable_three;
        logic [31:0] status;
        logic [31:0] mask;
        logic [31:0] prdata;
        logic slverr;
    } ieb_regs_t;

endpackage

// ---- core/ieb_top.sv ----
// Behaviour
// - An enable bit at 1 passes its source request; at 0 it blocks it.
// - Second register bit 2 gates the first CAN controller receive-ready request.
// - Second register bit 1 gates the second SPI unit event request.
// - Second register bit 0 gates the second SPI unit error request.
// - Third register bit 13 gates the DMA channel 5 transfer-done request.
// - Third register bits 14, 12 and 11 read zero and ignore writes.
// - Third register bit 9 gates the motor PWM error request.
// - Third register bit 1 gates the second I2C unit slave-events request.
// - Third register bit 0 gates the timer 7 request.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module ieb_top
    import ieb_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flags, second register sources
    input wire logic [15:3] flag_two_upper,
    input wire logic can_one_receive,
    input wire logic spi_two_event,
    input wire logic spi_two_error,
    // Flags, third register sources
    input wire logic pwm_fault_a,
    input wire logic dma_five_done,
    input wire logic quad_encoder,
    input wire logic pwm_error,
    input wire logic can_two_event,
    input wire logic can_two_receive,
    input wire logic ext_irq_four,
    input wire logic ext_irq_three,
    input wire logic timer_nine,
    input wire logic timer_eight,
    input wire logic i2c_two_master,
    input wire logic i2c_two_slave,
    input wire logic timer_seven,
    // Gated requests, second register sources
    output logic [15:3] req_two_upper,
    output logic can_one_receive_req,
    output logic spi_two_event_req,
    output logic spi_two_error_req,
    // Gated requests, third register sources
    output logic pwm_fault_a_req,
    output logic dma_five_done_req,
    output logic quad_encoder_req,
    output logic pwm_error_req,
    output logic can_two_event_req,
    output logic can_two_receive_req,
    output logic ext_irq_four_req,
    output logic ext_irq_three_req,
    output logic timer_nine_req,
    output logic timer_eight_req,
    output logic i2c_two_master_req,
    output logic i2c_two_slave_req,
    output logic timer_seven_req,
    // Interrupt to the core
    output logic irq
);

    import ieb_pkg::*;

    // The decode reads paddr[7:0], so narrower buses cannot be served
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ieb_top: ADDR_W must lie between 8 and 32");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ieb_regs_t regs_q;
    ieb_regs_t regs_d;

    logic [15:0] flag_two;
    logic [15:0] flag_three;
    logic [31:0] gate_flag;
    logic [31:0] gate_en;
    logic [31:0] gate_req;
    logic [31:0] gate_evt;

    logic setup_phase;
    logic access_phase;
    logic wr_access;
    logic rd_access;
    logic [7:0] addr_lo;
    logic addr_hi_zero;
    logic hit_two;
    logic hit_three;
    logic hit_status;
    logic hit_mask;
    logic hit_request;
    logic addr_mapped;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------------
    // Source flags into register bit order
    // ------------------------------------------------------------------
    always_comb begin
        flag_two = '0;
        flag_two[15:IEB_B2_UPPER_LO] = flag_two_upper;
        flag_two[IEB_B2_CAN_ONE_RX] = can_one_receive;
        flag_two[IEB_B2_SPI_TWO_EVT] = spi_two_event;
        flag_two[IEB_B2_SPI_TWO_ERR] = spi_two_error;
    end

    always_comb begin
        flag_three = '0;
        flag_three[IEB_B3_PWM_FAULT_A] = pwm_fault_a;
        flag_three[IEB_B3_DMA_FIVE] = dma_five_done;
        flag_three[IEB_B3_QUAD_ENC] = quad_encoder;
        flag_three[IEB_B3_PWM_ERR] = pwm_error;
        flag_three[IEB_B3_CAN_TWO_EVT] = can_two_event;
        flag_three[IEB_B3_CAN_TWO_RX] = can_two_receive;
        flag_three[IEB_B3_EXT_FOUR] = ext_irq_four;
        flag_three[IEB_B3_EXT_THREE] = ext_irq_three;
        flag_three[IEB_B3_TIMER_NINE] = timer_nine;
        flag_three[IEB_B3_TIMER_EIGHT] = timer_eight;
        flag_three[IEB_B3_I2C_MASTER] = i2c_two_master;
        flag_three[IEB_B3_I2C_SLAVE] = i2c_two_slave;
        flag_three[IEB_B3_TIMER_SEVEN] = timer_seven;
    end

    // Unimplemented enable bits are held at zero, so they never gate
    assign gate_flag = {flag_three, flag_two};
    assign gate_en = {regs_q.enable_three, regs_q.enable_two};

    // ------------------------------------------------------------------
    // Gate bank
    // ------------------------------------------------------------------
    ieb_gate #(
        .WIDTH(IEB_SRC_W)
    ) u_gate (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .flag(gate_flag),
        .enable(gate_en),
        .req(gate_req),
        .evt(gate_evt)
    );

    // ------------------------------------------------------------------
    // Gated request outputs
    // ------------------------------------------------------------------
    assign req_two_upper = gate_req[15:IEB_B2_UPPER_LO];
    assign can_one_receive_req = gate_req[IEB_B2_CAN_ONE_RX];
    assign spi_two_event_req = gate_req[IEB_B2_SPI_TWO_EVT];
    assign spi_two_error_req = gate_req[IEB_B2_SPI_TWO_ERR];
    assign dma_five_done_req = gate_req[16 + IEB_B3_DMA_FIVE];
    assign pwm_error_req = gate_req[16 + IEB_B3_PWM_ERR];
    assign i2c_two_slave_req = gate_req[16 + IEB_B3_I2C_SLAVE];
    assign timer_seven_req = gate_req[16 + IEB_B3_TIMER_SEVEN];
    assign pwm_fault_a_req = gate_req[16 + IEB_B3_PWM_FAULT_A];
    assign quad_encoder_req = gate_req[16 + IEB_B3_QUAD_ENC];
    assign can_two_event_req = gate_req[16 + IEB_B3_CAN_TWO_EVT];
    assign can_two_receive_req = gate_req[16 + IEB_B3_CAN_TWO_RX];
    assign ext_irq_four_req = gate_req[16 + IEB_B3_EXT_FOUR];
    assign ext_irq_three_req = gate_req[16 + IEB_B3_EXT_THREE];
    assign timer_nine_req = gate_req[16 + IEB_B3_TIMER_NINE];
    assign timer_eight_req = gate_req[16 + IEB_B3_TIMER_EIGHT];
    assign i2c_two_master_req = gate_req[16 + IEB_B3_I2C_MASTER];

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign wr_access = access_phase & pwrite;
    assign rd_access = access_phase & ~pwrite;
    assign addr_lo = paddr[7:0];

    always_comb begin
        addr_hi_zero = 1'b1;
        for (int i = 8; i < ADDR_W; i++) begin
            if (paddr[i]) begin
                addr_hi_zero = 1'b0;
            end
        end
    end

    assign hit_two = addr_hi_zero & (addr_lo == IEB_OFF_ENABLE_TWO);
    assign hit_three = addr_hi_zero & (addr_lo == IEB_OFF_ENABLE_THREE);
    assign hit_status = addr_hi_zero & (addr_lo == IEB_OFF_STATUS);
    assign hit_mask = addr_hi_zero & (addr_lo == IEB_OFF_MASK);
    assign hit_request = addr_hi_zero & (addr_lo == IEB_OFF_REQUEST);
    assign addr_mapped = hit_two | hit_three | hit_status | hit_mask | hit_request;

    // Zero-wait slave: read data is captured in setup, so access is ready
    assign pready = access_phase;

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux = IEB_RST_RDATA;
        if (hit_two) begin
            rd_mux = {16'h0000, regs_q.enable_two & IEB_IMPL_TWO};
        end else if (hit_three) begin
            rd_mux = {16'h0000, regs_q.enable_three & IEB_IMPL_THREE};
        end else if (hit_status) begin
            // Events landing this cycle show on the next read, not lost
            rd_mux = regs_q.status;
        end else if (hit_mask) begin
            rd_mux = regs_q.mask;
        end else if (hit_request) begin
            rd_mux = gate_req;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        regs_d = regs_q;

        // Read data and error are latched in setup and held for access
        if (setup_phase) begin
            regs_d.prdata = pwrite ? IEB_RST_RDATA : rd_mux;
            regs_d.slverr = ~addr_mapped;
        end

        // Enable writes; unimplemented bits never take a one
        if (wr_access && hit_two) begin
            regs_d.enable_two = pwdata[15:0] & IEB_IMPL_TWO;
        end
        if (wr_access && hit_three) begin
            regs_d.enable_three = pwdata[15:0] & IEB_IMPL_THREE;
        end
        if (wr_access && hit_mask) begin
            regs_d.mask = pwdata;
        end

        // Read clears only the bits it returned; later events survive
        if (rd_access && hit_status) begin
            regs_d.status = (regs_q.status & ~regs_q.prdata) | gate_evt;
        end else begin
            regs_d.status = regs_q.status | gate_evt;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            regs_q.enable_two <= IEB_RST_ENABLE;
            regs_q.enable_three <= IEB_RST_ENABLE;
            regs_q.status <= IEB_RST_STATUS;
            regs_q.mask <= IEB_RST_MASK;
            regs_q.prdata <= IEB_RST_RDATA;
            regs_q.slverr <= 1'b0;
        end else begin
            regs_q <= regs_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata = regs_q.prdata;
    assign pslverr = access_phase & regs_q.slverr;
    assign irq = |(regs_q.status & regs_q.mask);

endmodule

`default_nettype wire
